/* bench/usmp_serial_peer.sv */
/*
 * Behavioural peer on the shared serial line: sends and captures frames.
 * Assumes a sample tick every clock, so a bit lasts spb clocks.
 */
module usmp_serial_peer (
    input  wire logic clock,
    input  wire logic serialOut,
    output logic      serialIn
);
    timeunit 1ns;
    timeprecision 1ps;
    int         nbits = 8;
    int         spb   = 16;
    logic [8:0] got[$];

    initial serialIn = 1'b1;

    // Start, data LSB first, type stop, then a second stop bit
    task automatic send(input logic [8:0] d, input logic stop1);
        logic [11:0] fr;
        fr = 12'h000;
        for (int i = 0; i < nbits; i++) fr[i + 1] = d[i];
        fr[nbits + 1] = stop1;
        fr[nbits + 2] = 1'b1;
        for (int i = 0; i < nbits + 3; i++) begin
            serialIn <= fr[i];
            repeat (spb) @(posedge clock);
        end
    endtask

    // Capture device frames, sampled mid-bit; line idles high between them
    always begin : capture
        logic [8:0] v;
        @(posedge clock iff serialOut === 1'b0);
        v = 9'h000;
        repeat (spb / 2) @(posedge clock);
        for (int i = 0; i < nbits; i++) begin
            repeat (spb) @(posedge clock);
            v[i] = serialOut;
        end
        repeat (spb) @(posedge clock);
        got.push_back(v);
    end
endmodule // usmp_serial_peer

/* bench/usmp_transceiver_sva.sv */
/*
 * Port checker for the multi-drop serial transceiver.
 * Assumes one clock, asynchronous active-high rst, bound onto the top module.
 */
module usmp_transceiver_sva #(
    parameter logic [11:0] DIVISOR_RESET = usmp_pkg::RESET_DIVISOR
) (
    input wire logic       clock,
    input wire logic       rst,
    input wire logic [2:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic       regWrite,
    input wire logic       regRead,
    input wire logic [7:0] regRdData,
    input wire logic       serialIn,
    input wire logic       serialOut,
    input wire logic       txCompleteFlag,
    input wire logic       rxCompleteFlag
);
    // Strobes that may empty the receive buffer
    wire dataAcc = (regWrite || regRead) && (regAddr == 3'h0);
    wire ctrlBWr = regWrite && (regAddr == 3'h2);

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    // Start bit is never shorter than one bit at the fastest divisor
    sequence s_start_low;
        (!serialOut) [*8];
    endsequence
    // Clear request while the line is idle, so no completion can race it
    sequence s_clear_txc;
        regWrite && (regAddr == 3'h1) && regWrData[6] && txCompleteFlag && serialOut;
    endsequence

    a_rd_idle_zero: assert property (!regRead |=> regRdData == 8'h00)
        else $error("read data not zero outside a read");
    a_gap_read_zero: assert property (regRead && regAddr[2:1] == 2'b11 |=> regRdData == 8'h00)
        else $error("unmapped read returned data");
    a_start_bit_len: assert property ($fell(serialOut) |-> s_start_low)
        else $error("start bit too short");
    a_txc_clear: assert property (s_clear_txc |-> ##2 !txCompleteFlag)
        else $error("transmit complete not cleared by write of one");
    a_txc_rise_idle: assert property ($rose(txCompleteFlag) |-> serialOut && $past(serialOut))
        else $error("transmit complete while line not idle");
    a_txc_status_copy: assert property (regRead && regAddr == 3'h1 |=> regRdData[6] == txCompleteFlag)
        else $error("status bit and complete output disagree");
    a_rxc_fall_cause: assert property ($fell(rxCompleteFlag) |->
        $past(dataAcc) || $past(dataAcc, 2) || $past(ctrlBWr) || $past(ctrlBWr, 2))
        else $error("receive complete dropped without an access");
    a_parity_bit_zero: assert property (regRead && regAddr == 3'h1 |=> regRdData[2] == 1'b0)
        else $error("parity error bit set without parity support");
endmodule // usmp_transceiver_sva

bind usmp_transceiver usmp_transceiver_sva #(.DIVISOR_RESET(DIVISOR_RESET)) u_sva (
    .clock(clock), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .serialIn(serialIn),
    .serialOut(serialOut), .txCompleteFlag(txCompleteFlag), .rxCompleteFlag(rxCompleteFlag)
);

/* bench/usmp_transceiver_tb.sv */
/*
 * Self-checking bench for the transceiver with a queue model of the FIFO.
 * Assumes divisor 0, so one sample tick per 40 ns clock.
 */
module usmp_transceiver_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clock, rst, regWrite, regRead, filt;
    logic [2:0] regAddr;
    logic [7:0] regWrData, v, x, y;
    wire  [7:0] regRdData;
    wire        serialIn, serialOut, txCompleteFlag, rxCompleteFlag;
    int         err_total = 0;
    int         comparisons = 0;
    int         nb = 8;
    logic [8:0] rxq[$];

    usmp_transceiver #(.DIVISOR_RESET(12'h000)) DUT (.clock(clock), .rst(rst),
        .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData(regRdData), .serialIn(serialIn), .serialOut(serialOut),
        .txCompleteFlag(txCompleteFlag), .rxCompleteFlag(rxCompleteFlag));
    usmp_serial_peer peer (.clock(clock), .serialOut(serialOut), .serialIn(serialIn));

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    task automatic final_report;
        if (err_total == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk_byte(input logic [8:0] got, input logic [8:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Any data-location write also advances the model FIFO
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge clock);
        regWrite <= 1'b0;
        if (a == 3'h0 && rxq.size() > 0) void'(rxq.pop_front());
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clock);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clock);
        regRead <= 1'b0;
        #1 d = regRdData;
    endtask

    task automatic rxflag;
        repeat (2) @(posedge clock);
        #1 chk_bit(rxCompleteFlag, rxq.size() != 0);
    endtask

    // Peer sends one frame; model keeps it unless filtered or FIFO full
    task automatic rxf(input logic [8:0] d, input logic s);
        logic typ;
        typ = (nb == 9) ? d[8] : s;
        peer.send(d, s);
        if ((!filt || typ) && rxq.size() < 2) rxq.push_back(d & 9'((1 << nb) - 1));
        rxflag();
    endtask

    task automatic rdd;
        logic [8:0] e;
        e = rxq.pop_front();
        rd(3'h0, v);
        chk_byte({1'b0, v}, {1'b0, e[7:0]});
    endtask

    // Bounded wait for a captured transmit frame, then compare it
    task automatic txchk(input logic [8:0] exp);
        repeat (3000) if (peer.got.size() == 0) @(posedge clock);
        chk_bit(peer.got.size() != 0, 1'b1);
        if (peer.got.size() != 0) chk_byte(peer.got.pop_front(), exp);
    endtask

    initial begin
        repeat (40000) @(posedge clock);
        err_total++;
        final_report();
    end

    initial begin
        regAddr = 3'h0;
        regWrData = 8'h00;
        regWrite = 1'b0;
        regRead = 1'b0;
        filt = 1'b0;
        rst = 1'b1;
        void'($urandom(32'h6e3c));
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        // Reset values, then an unmapped address
        rd(3'h1, v); chk_byte({1'b0, v}, 9'h020);
        rd(3'h2, v); chk_byte({1'b0, v}, 9'h000);
        rd(3'h3, v); chk_byte({1'b0, v}, 9'h006);
        rd(3'h6, v); chk_byte({1'b0, v}, 9'h000);
        // Filter on while sending; third write hits a full buffer
        x = 8'($urandom);
        y = 8'($urandom);
        wr(3'h2, 8'h18);
        wr(3'h1, 8'h01);
        wr(3'h0, x);
        repeat (4) @(posedge clock);
        wr(3'h0, y);
        wr(3'h0, ~y);
        txchk({1'b0, x});
        txchk({1'b0, y});
        repeat (400) @(posedge clock);
        chk_bit(peer.got.size() == 0, 1'b1);
        chk_bit(txCompleteFlag, 1'b1);
        wr(3'h1, 8'h41);
        repeat (2) @(posedge clock);
        #1 chk_bit(txCompleteFlag, 1'b0);
        // Eight-bit frames typed by the first stop bit
        filt = 1'b1;
        rxf({1'b0, x}, 1'b0);
        rxf({1'b0, y}, 1'b1);
        rdd();
        wr(3'h1, 8'h00);
        filt = 1'b0;
        rxf({1'b0, x}, 1'b0);
        rd(3'h1, v); chk_bit(v[4], 1'b1);
        rdd();
        // Nine-bit frames typed by the ninth bit, both directions
        wr(3'h2, 8'h1d);
        wr(3'h1, 8'h01);
        filt = 1'b1;
        nb = 9;
        peer.nbits = 9;
        rxf({1'b0, x}, 1'b1);
        rxf({1'b1, y}, 1'b1);
        rd(3'h2, v); chk_bit(v[1], 1'b1);
        rdd();
        wr(3'h0, x);
        txchk({1'b1, x});
        // Five-bit characters drop and clear the upper bits
        wr(3'h2, 8'h18);
        wr(3'h3, 8'h00);
        wr(3'h1, 8'h00);
        filt = 1'b0;
        nb = 5;
        peer.nbits = 5;
        wr(3'h0, 8'hff);
        txchk(9'h01f);
        rxf(9'h1ff, 1'b1);
        rdd();
        // Three frames into a two-entry buffer, then a flush
        wr(3'h3, 8'h06);
        nb = 8;
        peer.nbits = 8;
        for (int i = 0; i < 3; i++) rxf({1'b0, 8'($urandom)}, 1'b1);
        rd(3'h1, v); chk_byte({1'b0, v & 8'h88}, 9'h088);
        rdd();
        rdd();
        rxflag();
        rxf({1'b0, y}, 1'b1);
        wr(3'h2, 8'h08);
        rxq.delete();
        rxflag();
        // Double speed: eight samples per bit
        wr(3'h2, 8'h18);
        wr(3'h1, 8'h02);
        peer.spb = 8;
        rxf({1'b0, x}, 1'b1);
        rdd();
        wr(3'h0, y);
        txchk({1'b0, y});
        final_report();
    end
endmodule // usmp_transceiver_tb

/* hdl/usmp_pkg.sv */
/*
 * Shared constants and types for the multi-drop serial transceiver.
 * Assumes a single 25 MHz system clock and a plain register port.
 */
package usmp_pkg;
    localparam int CLOCK_HZ         = 25000000;
    localparam logic [1:0] ADDR_DATA   = 2'h0;
    localparam logic [1:0] ADDR_CTRLA  = 2'h1;
    localparam logic [1:0] ADDR_CTRLB  = 2'h2;
    localparam logic [1:0] ADDR_CTRLC  = 2'h3;
    // Status/control A field positions
    localparam int A_RXC  = 7;
    localparam int A_TXC  = 6;
    localparam int A_UDRE = 5;
    localparam int A_FE   = 4;
    localparam int A_DOR  = 3;
    localparam int A_U2X  = 1;
    localparam int A_MPCM = 0;
    // Control B field positions
    localparam int B_RXEN = 4;
    localparam int B_TXEN = 3;
    localparam int B_SZ2  = 2;
    localparam int B_RXB8 = 1;
    localparam int B_TXB8 = 0;
    // Control C field positions
    localparam int C_USBS = 3;
    localparam int C_SZ1  = 2;
    localparam int C_SZ0  = 1;
    localparam logic [7:0] RESET_A = 8'h20;
    localparam logic [7:0] RESET_B = 8'h00;
    localparam logic [7:0] RESET_C = 8'h06;
    localparam logic [2:0] SIZE_NINE = 3'h7;
    localparam logic [3:0] SAMPLES_NORMAL = 4'hf;  // 16 samples, counted 0..15
    localparam logic [3:0] SAMPLES_DOUBLE = 4'h7;  // 8 samples, counted 0..7
    localparam logic [3:0] VOTE_FIRST_NORMAL = 4'h8;
    localparam logic [3:0] VOTE_FIRST_DOUBLE = 4'h4;
    localparam logic [11:0] RESET_DIVISOR = 12'h00c;
    localparam int FIFO_DEPTH = 2;

    typedef enum logic [1:0] {
        LINE_IDLE  = 2'b00,
        LINE_START = 2'b01,
        LINE_BITS  = 2'b11,
        LINE_STOP  = 2'b10
    } usmp_line_t;

    typedef struct packed {
        logic [8:0] data;
        logic       frameErr;
    } usmp_rx_entry_t;
endpackage

/* hdl/usmp_transceiver.sv */
/*
 * Asynchronous serial transceiver with receive address filtering, a shared
 * data register, a two-entry receive FIFO and 16x/8x oversampled reception.
 * Assumes the serial input is already synchronous to clock and the register
 * master never issues read and write strobes together.
 */
// Design decisions made here: the plain strobed port and the register addresses.
// Function
// - With filter mode set, non-address frames are dropped before the receive FIFO.
// - Transmitter logic ignores the filter mode bit entirely.
// - For five to eight data bits, the first stop bit is the frame type.
// - For nine data bits, the ninth bit is frame type and stored ninth bit.
// - Frame type one means address frame, zero means data frame.
// - Address frames under filtering are stored and flagged like normal frames.
// - Transmitter and receiver share one character-size setting.
// - One data address writes the transmit buffer and reads the receive head.
// - Short characters: unused upper bits ignored on send, zero on receive.
// - Data writes while the buffer-empty flag is clear are discarded.
// - Enabled transmitter loads the shifter when empty and shifts it out.
// - Receive buffer is a two-entry FIFO advanced by every data access.
// - Each bit sampled 16 times normally and 8 times in double speed.
// - Vote window starts at sample 8 or 4, middle at 9 or 5.
// - Baud error within recommended limits, split between both ends.
// - Transmit-complete clears when software writes one to its bit.
// - Buffer-empty flag reads one after reset.
// - Receive-complete shows unread data; cleared when empty or receiver off.
module usmp_transceiver #(
    parameter logic [11:0] DIVISOR_RESET = usmp_pkg::RESET_DIVISOR
) (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic [2:0] regAddr,
    input  wire logic [7:0] regWrData,
    input  wire logic       regWrite,
    input  wire logic       regRead,
    output logic      [7:0] regRdData,
    input  wire logic       serialIn,
    output logic            serialOut,
    output logic            txCompleteFlag,
    output logic            rxCompleteFlag
);
    // Width of a character from the shared size code
    function automatic logic [3:0] char_bits(input logic [2:0] code);
        unique case (code)
            3'h0:    char_bits = 4'h5;
            3'h1:    char_bits = 4'h6;
            3'h2:    char_bits = 4'h7;
            3'h7:    char_bits = 4'h9;
            default: char_bits = 4'h8;
        endcase
    endfunction

    // Keep only the low n bits of a character
    function automatic logic [8:0] trim(input logic [8:0] v, input logic [3:0] n);
        trim = v & ~(9'h1ff << n);
    endfunction

    logic [7:0]  ctrlA;
    logic [7:0]  ctrlB;
    logic [7:0]  ctrlC;
    logic [11:0] baudDivisor;
    logic [11:0] baudCount;
    logic        txComplete;
    logic        txBufFull;
    logic [8:0]  txDataBuffer;
    logic [11:0] txShift;
    logic [3:0]  txBitsLeft;
    logic [3:0]  txSample;
    logic        txBusy;
    usmp_pkg::usmp_line_t rxState;
    logic [3:0]  rxSample;
    logic [3:0]  rxBitIdx;
    logic [8:0]  rxShift;
    logic [2:0]  votes;
    usmp_pkg::usmp_rx_entry_t rxFifo [usmp_pkg::FIFO_DEPTH];
    logic [1:0]  rxCount;
    logic        overrun;

    // Shared size setting for both directions
    wire [2:0] charSizeCode  = {ctrlB[usmp_pkg::B_SZ2], ctrlC[usmp_pkg::C_SZ1],
                                ctrlC[usmp_pkg::C_SZ0]};
    wire [3:0] nBits         = char_bits(charSizeCode);
    wire       nineBit       = (charSizeCode == usmp_pkg::SIZE_NINE);
    wire       addrFilterMode = ctrlA[usmp_pkg::A_MPCM];
    wire       doubleSpeedSel = ctrlA[usmp_pkg::A_U2X];
    wire       rxEnable      = ctrlB[usmp_pkg::B_RXEN];
    wire       txEnable      = ctrlB[usmp_pkg::B_TXEN];
    wire       stopBitSelect = ctrlC[usmp_pkg::C_USBS];
    wire [3:0] lastSample    = doubleSpeedSel ? usmp_pkg::SAMPLES_DOUBLE
                                              : usmp_pkg::SAMPLES_NORMAL;
    wire [3:0] voteFirst     = doubleSpeedSel ? usmp_pkg::VOTE_FIRST_DOUBLE
                                              : usmp_pkg::VOTE_FIRST_NORMAL;
    wire       tick          = (baudCount == 12'h000);

    // Register port decode
    wire dataAccess = (regAddr[1:0] == usmp_pkg::ADDR_DATA) && !regAddr[2];
    wire wrData     = regWrite && dataAccess;
    wire wrA        = regWrite && !regAddr[2] && regAddr[1:0] == usmp_pkg::ADDR_CTRLA;
    wire wrB        = regWrite && !regAddr[2] && regAddr[1:0] == usmp_pkg::ADDR_CTRLB;
    wire wrC        = regWrite && !regAddr[2] && regAddr[1:0] == usmp_pkg::ADDR_CTRLC;
    wire wrDivLo    = regWrite && regAddr == 3'h4;
    wire wrDivHi    = regWrite && regAddr == 3'h5;
    // Any strobe on the data location pops, so bit tests count too
    wire rxPop      = (regRead || regWrite) && dataAccess && rxCount != 2'h0;
    wire txAccept   = wrData && !txBufFull;

    // Receiver majority vote and frame classification
    // Third vote sample is the live input, so samples 8, 9, 10 (4, 5, 6) decide
    wire voteBit    = (votes[0] & votes[1]) | (votes[1] & serialIn)
                    | (votes[0] & serialIn);
    wire inVote     = rxSample >= voteFirst && rxSample <= voteFirst + 4'h2;
    wire voteDone   = tick && rxSample == voteFirst + 4'h2;
    // Frame type: ninth bit for 9-bit, first stop bit otherwise
    wire frameType  = nineBit ? rxShift[8] : voteBit;
    wire isAddress  = frameType;
    wire frameEnd   = rxState == usmp_pkg::LINE_STOP && voteDone;
    wire keepFrame  = !addrFilterMode || isAddress;
    wire rxPush     = frameEnd && keepFrame && rxEnable;
    wire fifoFull   = rxCount == 2'(usmp_pkg::FIFO_DEPTH);
    wire [8:0] rxHeadData = rxCount != 2'h0 ? rxFifo[0].data : 9'h000;
    wire [1:0] next_rxCount = rxCount + 2'(rxPush && !fifoFull) - 2'(rxPop);

    // Read data mux; reserved addresses read zero
    wire [7:0] statusA = {rxCount != 2'h0, txComplete, !txBufFull,
                          rxCount != 2'h0 && rxFifo[0].frameErr, overrun,
                          1'b0, doubleSpeedSel, addrFilterMode};
    wire [7:0] statusB = {ctrlB[7:2], rxHeadData[8], ctrlB[usmp_pkg::B_TXB8]};
    logic [7:0] next_rdData;
    always_comb begin
        unique case (regAddr)
            3'h0:    next_rdData = rxHeadData[7:0];
            3'h1:    next_rdData = statusA;
            3'h2:    next_rdData = statusB;
            3'h3:    next_rdData = ctrlC;
            3'h4:    next_rdData = baudDivisor[7:0];
            3'h5:    next_rdData = {4'h0, baudDivisor[11:8]};
            default: next_rdData = 8'h00;
        endcase
    end

    // Read data held for exactly the cycle after the strobe
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            regRdData <= 8'h00;
        end else begin
            regRdData <= regRead ? next_rdData : 8'h00;
        end
    end

    // Control registers; status bits in A are read-only
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctrlA       <= usmp_pkg::RESET_A;
            ctrlB       <= usmp_pkg::RESET_B;
            ctrlC       <= usmp_pkg::RESET_C;
            baudDivisor <= DIVISOR_RESET;
        end else begin
            if (wrA) begin
                ctrlA <= {6'h00, regWrData[usmp_pkg::A_U2X], regWrData[usmp_pkg::A_MPCM]};
            end
            if (wrB) begin
                ctrlB <= regWrData;
            end
            if (wrC) begin
                ctrlC <= regWrData;
            end
            if (wrDivLo) begin
                baudDivisor[7:0] <= regWrData;
            end
            if (wrDivHi) begin
                baudDivisor[11:8] <= regWrData[3:0];
            end
        end
    end

    // Sample-rate divider shared by both directions
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            baudCount <= 12'h000;
        end else begin
            baudCount <= tick ? baudDivisor : baudCount - 12'h001;
        end
    end

    // Transmit buffer and shifter; filter mode plays no part here
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            txBufFull    <= 1'b0;
            txDataBuffer <= 9'h000;
            txShift      <= 12'hfff;
            txBitsLeft   <= 4'h0;
            txSample     <= 4'h0;
            txBusy       <= 1'b0;
            txComplete   <= 1'b0;
            serialOut    <= 1'b1;
        end else begin
            if (txAccept) begin
                txBufFull    <= 1'b1;
                txDataBuffer <= trim({ctrlB[usmp_pkg::B_TXB8], regWrData}, nBits);
            end
            if (!txBusy && txBufFull && txEnable && !txAccept) begin
                txBufFull  <= 1'b0;
                txBusy     <= 1'b1;
                txShift    <= {2'h3, txDataBuffer | ~trim(9'h1ff, nBits), 1'b0}; // Ones as stop
                txBitsLeft <= nBits + 4'h2 + 4'(stopBitSelect);
                txSample   <= 4'h0;
            end else if (txBusy && tick) begin
                txSample <= txSample == lastSample ? 4'h0 : txSample + 4'h1;
                if (txSample == 4'h0) begin
                    serialOut <= txShift[0];
                end
                if (txSample == lastSample) begin
                    txShift    <= {1'b1, txShift[11:1]};
                    txBitsLeft <= txBitsLeft - 4'h1;
                    if (txBitsLeft == 4'h1) begin
                        txBusy <= 1'b0;
                    end
                end
            end
            // Completion wins over a same-cycle software clear
            if (txBusy && tick && txSample == lastSample && txBitsLeft == 4'h1
                    && !txBufFull) begin
                txComplete <= 1'b1;
            end else if (wrA && regWrData[usmp_pkg::A_TXC]) begin
                txComplete <= 1'b0;
            end
        end
    end

    // Receive framing: start check, data bits, first stop bit
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rxState  <= usmp_pkg::LINE_IDLE;
            rxSample <= 4'h0;
            rxBitIdx <= 4'h0;
            rxShift  <= 9'h000;
            votes    <= 3'h7;
        end else if (!rxEnable) begin
            rxState <= usmp_pkg::LINE_IDLE;                                    // Disable is immediate
        end else if (tick) begin
            rxSample <= rxSample == lastSample ? 4'h0 : rxSample + 4'h1;
            if (inVote) begin
                votes <= {votes[1:0], serialIn};
            end
            unique case (rxState)
                usmp_pkg::LINE_IDLE: begin
                    rxSample <= serialIn ? 4'h1 : 4'h2;                        // Low sample here is 1
                    if (!serialIn) begin
                        rxState <= usmp_pkg::LINE_START;
                    end
                end
                usmp_pkg::LINE_START: begin
                    if (voteDone) begin
                        rxState  <= voteBit ? usmp_pkg::LINE_IDLE : usmp_pkg::LINE_BITS;
                        rxBitIdx <= 4'h0;
                    end
                end
                usmp_pkg::LINE_BITS: begin
                    if (voteDone) begin
                        rxShift  <= {voteBit, rxShift[8:1]};
                        rxBitIdx <= rxBitIdx + 4'h1;
                        if (rxBitIdx == nBits - 4'h1) begin
                            rxState <= usmp_pkg::LINE_STOP;
                        end
                    end
                end
                usmp_pkg::LINE_STOP: begin
                    if (voteDone) begin
                        rxState <= usmp_pkg::LINE_IDLE;                        // Only first stop used
                    end
                end
            endcase
        end
    end

    // Align the assembled character to bit 0, upper bits zero
    wire [8:0] rxChar = trim(rxShift >> (4'h9 - nBits), nBits);

    // Two-entry receive FIFO; flushed when the receiver is off
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rxCount <= 2'h0;
            overrun <= 1'b0;
            for (int i = 0; i < usmp_pkg::FIFO_DEPTH; i++) begin
                rxFifo[i] <= '0;
            end
        end else if (!rxEnable) begin
            rxCount <= 2'h0;
            overrun <= 1'b0;
        end else begin
            rxCount <= next_rxCount;
            if (rxPop) begin
                rxFifo[0] <= rxFifo[1];
            end
            if (rxPush && !fifoFull) begin
                rxFifo[rxPop ? 1'b0 : rxCount[0]] <= '{data: rxChar, frameErr: !voteBit};
                overrun <= 1'b0;
            end else if (rxPush) begin
                overrun <= 1'b1;
            end
        end
    end

    // Flag outputs registered for clean edges
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            txCompleteFlag <= 1'b0;
            rxCompleteFlag <= 1'b0;
        end else begin
            txCompleteFlag <= txComplete;
            rxCompleteFlag <= next_rxCount != 2'h0 && rxEnable;
        end
    end
endmodule // usmp_transceiver
